// file: design/math_postproc_map.vh
// Purpose: Constants shared by the reading math post-processor
// Assumes: Included by its bare name
// Notes: Register offsets are byte addresses on a 32-bit APB
`ifndef MATH_POSTPROC_MAP_VH
`define MATH_POSTPROC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_OFFSET 8'h04
`define REG_LEVEL_REF 8'h08
`define REG_REF_RES 8'h0C
`define REG_UPPER 8'h10
`define REG_LOWER 8'h14
`define REG_MIN 8'h18
`define REG_MAX 8'h1C
`define REG_AVG 8'h20
`define REG_COUNT 8'h24
`define REG_QUES_EVENT 8'h28
`define REG_QUES_ENABLE 8'h2C
`define REG_STATUS 8'h30
`define REG_RESULT 8'h34

// ----------------------------------------
// Fields
// ----------------------------------------
`define CTRL_OP_MSB 2
`define CTRL_ENABLE_BIT 3
`define STATUS_CLS_BIT 0
`define STATUS_REJECT_BIT 1
`define QUES_UPPER_BIT 11
`define QUES_LOWER_BIT 12
`define QUES_MASK 16'h1800

// ----------------------------------------
// Math operations
// ----------------------------------------
`define OP_AVG 3'h0
`define OP_LEVEL 3'h1
`define OP_POWER 3'h2
`define OP_LIMIT 3'h3
`define OP_NULL 3'h4

// ----------------------------------------
// Reference resistance, centi-dB of 10*log10(R)
// ----------------------------------------
`define RES_COUNT 5'h11
`define RES_IDX_DEFAULT 5'h0B
`define RES_TABLE {16'h06A3, 16'h0753, 16'h07B0, 16'h07F9, 16'h082D, 16'h0831, \
    16'h0852, 16'h0880, 16'h095E, 16'h09AD, 16'h0A8B, 16'h0ADA, 16'h0B57, \
    16'h0B8A, 16'h0BB8, 16'h0C07, 16'h0F3F}

// ----------------------------------------
// Arithmetic scaling
// ----------------------------------------
`define LOG_OCTAVE_CENTI 10'h25A
`define LOG_FRAC_BITS 8
`define DBM_UV_OFFSET 32'h0000_2328
`define LEVEL_REF_MAX 32'h0000_4E20
`define SUM_W 48

`endif

// file: design/log_level_conv.v
// Purpose: 20*log10 of an unsigned magnitude, in centi-dB
// Assumes: Combinational, magnitude of zero returns zero
// Notes: Linear interpolation inside each octave, error below 0.6 dB
`timescale 1ns/1ps
`include "math_postproc_map.vh"
module log_level_conv (
    // Operand
    input wire [31:0] magnitude,
    // Result
    output wire [15:0] level_centi
);
    reg [4:0] msb_pos;
    reg [31:0] norm;
    wire [12:0] log2_fix;
    wire [22:0] product;
    integer i;

    always @* begin
        msb_pos = 5'h00;
        for (i = 0; i < 32; i = i + 1) begin
            if (magnitude[i]) begin
                msb_pos = i[4:0];
            end
        end
        norm = magnitude << (5'h1F - msb_pos);
    end

    assign log2_fix = {msb_pos, norm[30:23]};
    assign product = log2_fix * `LOG_OCTAVE_CENTI;
    assign level_centi = {1'b0, product[22:`LOG_FRAC_BITS]};
endmodule // log_level_conv

// file: design/serial_divider.v
// Purpose: Unsigned restoring divider, one quotient bit per cycle
// Assumes: Divisor is nonzero when start is pulsed
// Notes: A new start aborts any division in progress
`timescale 1ns/1ps
`include "math_postproc_map.vh"
module serial_divider (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Request
    input wire start,
    input wire [`SUM_W-1:0] dividend,
    input wire [31:0] divisor,
    // Answer
    output reg done,
    output reg [`SUM_W-1:0] quotient
);
    reg [`SUM_W-1:0] shift_q;
    reg [32:0] remain;
    reg [31:0] div_hold;
    reg [5:0] steps;
    wire [32:0] trial;

    assign trial = {remain[31:0], shift_q[`SUM_W-1]} - {1'b0, div_hold};

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_q <= {`SUM_W{1'b0}};
            remain <= 33'h0_0000_0000;
            div_hold <= 32'h0000_0000;
            steps <= 6'h00;
            done <= 1'b0;
            quotient <= {`SUM_W{1'b0}};
        end else begin
            done <= 1'b0;
            if (start) begin
                shift_q <= dividend;
                remain <= 33'h0_0000_0000;
                div_hold <= divisor;
                steps <= 6'h30;
            end else if (steps != 6'h00) begin
                if (!trial[32]) begin
                    remain <= trial;
                    shift_q <= {shift_q[`SUM_W-2:0], 1'b1};
                end else begin
                    remain <= {remain[31:0], shift_q[`SUM_W-1]};
                    shift_q <= {shift_q[`SUM_W-2:0], 1'b0};
                end
                steps <= steps - 6'h01;
                if (steps == 6'h01) begin
                    done <= 1'b1;
                    quotient <= {shift_q[`SUM_W-2:0], ~trial[32]};
                end
            end
        end
    end
endmodule // serial_divider

// file: design/reading_math_postprocessor.v
// Purpose: Applies one selectable math operation to each reading
// Assumes: Readings arrive on sys_clk, voltages in microvolts, levels in centi-dB
// Notes: Registers reached over APB, zero wait states
`timescale 1ns/1ps
`include "math_postproc_map.vh"
module reading_math_postprocessor (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // Readings from the measurement engine
    input wire reading_valid,
    input wire [31:0] reading_data,
    input wire [2:0] meas_function,
    input wire func_is_voltage,
    input wire func_is_ratio,
    input wire [31:0] highest_range,
    // Processed result
    output reg result_valid,
    output reg [31:0] result_data,
    // Service request
    output wire srq,
    // Nonvolatile store for the reference resistance
    input wire [4:0] nv_res_index,
    output reg nv_res_write,
    output reg [4:0] nv_res_data
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [31:0] abs_val;
        input [31:0] v;
        begin
            abs_val = v[31] ? (32'h0000_0000 - v) : v;
        end
    endfunction

    function [31:0] res_centi;
        input [4:0] idx;
        reg [16*17-1:0] table_bits;
        begin
            table_bits = `RES_TABLE;
            res_centi = {16'h0000, table_bits[16*(5'h10-idx) +: 16]};
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg [2:0] op_sel;
    reg calc_en;
    reg [31:0] null_offset;
    reg offset_held;
    reg [31:0] level_ref;
    reg [4:0] ref_res_idx;
    reg nv_loaded;
    reg [31:0] upper_bound;
    reg [31:0] lower_bound;
    reg [31:0] stat_min;
    reg [31:0] stat_max;
    reg [31:0] stat_avg;
    reg [31:0] stat_count;
    reg [`SUM_W-1:0] stat_sum;
    reg avg_neg;
    reg [15:0] ques_event;
    reg [15:0] ques_enable;
    reg write_reject;
    reg [2:0] prev_function;
    reg prev_stats_on;

    wire wr_access;
    wire rd_setup;
    wire rd_access;
    wire func_changed;
    wire stats_on;
    wire stats_clear;
    wire null_start;
    wire [31:0] range_limit;
    wire val_in_range;
    wire level_in_range;
    wire addr_mapped;
    wire [15:0] level_centi;
    wire [31:0] power_val;
    wire [`SUM_W-1:0] next_sum;
    wire [31:0] next_count;
    wire div_done;
    wire [`SUM_W-1:0] div_quot;
    wire upper_fail;
    wire lower_fail;
    wire [15:0] next_event_set;

    assign pready = 1'b1;
    assign wr_access = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign rd_access = psel & penable & ~pwrite;
    assign addr_mapped = (paddr <= `REG_RESULT) && (paddr[1:0] == 2'b00);

    assign func_changed = (meas_function != prev_function);
    assign stats_on = calc_en & (op_sel == `OP_AVG);
    assign stats_clear = stats_on & ~prev_stats_on;

    // 120% of the highest range: range plus one fifth
    assign range_limit = highest_range + (highest_range / 32'h0000_0005);
    assign val_in_range = abs_val(pwdata) <= range_limit;
    assign level_in_range = abs_val(pwdata) <= `LEVEL_REF_MAX;

    // ----------------------------------------
    // Power level of the present reading
    // ----------------------------------------
    log_level_conv u_log (
        .magnitude(abs_val(reading_data)),
        .level_centi(level_centi)
    );

    // 20log10(uV) - 90 dB - 10log10(R) gives dB re 1 mW
    assign power_val = {16'h0000, level_centi} - `DBM_UV_OFFSET
        - res_centi(ref_res_idx);

    // ----------------------------------------
    // Running statistics
    // ----------------------------------------
    assign next_sum = stat_sum + {{(`SUM_W-32){reading_data[31]}}, reading_data};
    assign next_count = stat_count + 32'h0000_0001;

    // Divider runs in the background; a faster reading stream just restarts it
    serial_divider u_div (
        .sys_clk(sys_clk),
        .rst(rst),
        .start(stats_on & reading_valid),
        .dividend(next_sum[`SUM_W-1] ? ({`SUM_W{1'b0}} - next_sum) : next_sum),
        .divisor(next_count),
        .done(div_done),
        .quotient(div_quot)
    );

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stat_min <= 32'h0000_0000;
            stat_max <= 32'h0000_0000;
            stat_avg <= 32'h0000_0000;
            stat_count <= 32'h0000_0000;
            stat_sum <= {`SUM_W{1'b0}};
            avg_neg <= 1'b0;
            prev_stats_on <= 1'b0;
        end else begin
            prev_stats_on <= stats_on;
            if (stats_clear) begin
                stat_min <= 32'h0000_0000;
                stat_max <= 32'h0000_0000;
                stat_avg <= 32'h0000_0000;
                stat_count <= 32'h0000_0000;
                stat_sum <= {`SUM_W{1'b0}};
            end else if (stats_on & reading_valid) begin
                stat_sum <= next_sum;
                stat_count <= next_count;
                avg_neg <= next_sum[`SUM_W-1];
                if (stat_count == 32'h0000_0000) begin
                    stat_min <= reading_data;
                    stat_max <= reading_data;
                end else begin
                    if ($signed(reading_data) < $signed(stat_min)) begin
                        stat_min <= reading_data;
                    end
                    if ($signed(reading_data) > $signed(stat_max)) begin
                        stat_max <= reading_data;
                    end
                end
            end
            if (div_done & stats_on) begin
                stat_avg <= avg_neg ? (32'h0000_0000 - div_quot[31:0]) : div_quot[31:0];
            end
        end
    end

    // ----------------------------------------
    // Control and reference registers
    // ----------------------------------------
    assign null_start = calc_en & (op_sel == `OP_NULL) & reading_valid & ~func_is_ratio;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            op_sel <= `OP_AVG;
            calc_en <= 1'b0;
            null_offset <= 32'h0000_0000;
            offset_held <= 1'b0;
            level_ref <= 32'h0000_0000;
            upper_bound <= 32'h0000_0000;
            lower_bound <= 32'h0000_0000;
            ques_enable <= 16'h0000;
            write_reject <= 1'b0;
            prev_function <= 3'h0;
        end else begin
            prev_function <= meas_function;
            if (wr_access && paddr == `REG_CTRL) begin
                op_sel <= pwdata[`CTRL_OP_MSB:0];
                calc_en <= pwdata[`CTRL_ENABLE_BIT];
                if (pwdata[`CTRL_ENABLE_BIT] & ~calc_en) begin
                    write_reject <= 1'b0;
                end
            end
            if (wr_access && paddr == `REG_QUES_ENABLE) begin
                ques_enable <= pwdata[15:0] & `QUES_MASK;
            end
            if (wr_access && paddr == `REG_STATUS && pwdata[`STATUS_CLS_BIT]) begin
                write_reject <= 1'b0;
            end
            if (func_changed) begin
                null_offset <= 32'h0000_0000;
                offset_held <= 1'b0;
                level_ref <= 32'h0000_0000;
                upper_bound <= 32'h0000_0000;
                lower_bound <= 32'h0000_0000;
            end else if (wr_access && paddr == `REG_OFFSET) begin
                if (calc_en & val_in_range) begin
                    null_offset <= pwdata;
                    offset_held <= 1'b1;
                end else begin
                    write_reject <= 1'b1;
                end
            end else if (wr_access && paddr == `REG_LEVEL_REF) begin
                if (calc_en & level_in_range) begin
                    level_ref <= pwdata;
                end else begin
                    write_reject <= 1'b1;
                end
            end else if (wr_access && (paddr == `REG_UPPER || paddr == `REG_LOWER)) begin
                if (calc_en & val_in_range) begin
                    if (paddr == `REG_UPPER) begin
                        upper_bound <= pwdata;
                    end else begin
                        lower_bound <= pwdata;
                    end
                end else begin
                    write_reject <= 1'b1;
                end
            end else if (null_start & ~offset_held) begin
                null_offset <= reading_data;
                offset_held <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Reference resistance, backed by the nonvolatile store
    // ----------------------------------------
    // Reset only restores the default until the stored index is fetched
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ref_res_idx <= `RES_IDX_DEFAULT;
            nv_loaded <= 1'b0;
            nv_res_write <= 1'b0;
            nv_res_data <= `RES_IDX_DEFAULT;
        end else begin
            nv_res_write <= 1'b0;
            if (!nv_loaded) begin
                nv_loaded <= 1'b1;
                if (nv_res_index < `RES_COUNT) begin
                    ref_res_idx <= nv_res_index;
                end
            end else if (wr_access && paddr == `REG_REF_RES) begin
                if (calc_en && pwdata[31:0] < {27'h000_0000, `RES_COUNT}) begin
                    ref_res_idx <= pwdata[4:0];
                    nv_res_write <= 1'b1;
                    nv_res_data <= pwdata[4:0];
                end
            end
        end
    end

    // ----------------------------------------
    // Result path
    // ----------------------------------------
    assign upper_fail = calc_en & (op_sel == `OP_LIMIT) & reading_valid
        & ($signed(reading_data) > $signed(upper_bound));
    assign lower_fail = calc_en & (op_sel == `OP_LIMIT) & reading_valid
        & ($signed(reading_data) < $signed(lower_bound));

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            result_valid <= 1'b0;
            result_data <= 32'h0000_0000;
        end else begin
            result_valid <= reading_valid;
            if (reading_valid) begin
                result_data <= reading_data;
                if (calc_en) begin
                    case (op_sel)
                        `OP_NULL: begin
                            if (func_is_ratio) begin
                                result_data <= reading_data;
                            end else if (!offset_held) begin
                                result_data <= 32'h0000_0000;
                            end else begin
                                result_data <= reading_data - null_offset;
                            end
                        end
                        `OP_LEVEL: begin
                            if (func_is_voltage) begin
                                result_data <= power_val - level_ref;
                            end
                        end
                        `OP_POWER: begin
                            if (func_is_voltage) begin
                                result_data <= power_val;
                            end
                        end
                        default: begin
                            result_data <= reading_data;
                        end
                    endcase
                end
            end
        end
    end

    // ----------------------------------------
    // Questionable event register
    // ----------------------------------------
    assign next_event_set = ({15'h0000, upper_fail} << `QUES_UPPER_BIT)
        | ({15'h0000, lower_fail} << `QUES_LOWER_BIT);

    // A failure in the clearing cycle is kept: set wins over clear
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ques_event <= 16'h0000;
        end else if ((rd_access && paddr == `REG_QUES_EVENT)
                || (wr_access && paddr == `REG_STATUS && pwdata[`STATUS_CLS_BIT])) begin
            ques_event <= next_event_set;
        end else begin
            ques_event <= ques_event | next_event_set;
        end
    end

    assign srq = |(ques_event & ques_enable);

    // ----------------------------------------
    // APB read data and error
    // ----------------------------------------
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            pslverr <= ~addr_mapped;
            prdata <= 32'h0000_0000;
            if (rd_setup) begin
                case (paddr)
                    `REG_CTRL: prdata <= {28'h000_0000, calc_en, op_sel};
                    `REG_OFFSET: prdata <= null_offset;
                    `REG_LEVEL_REF: prdata <= level_ref;
                    `REG_REF_RES: prdata <= {27'h000_0000, ref_res_idx};
                    `REG_UPPER: prdata <= upper_bound;
                    `REG_LOWER: prdata <= lower_bound;
                    `REG_MIN: prdata <= stat_min;
                    `REG_MAX: prdata <= stat_max;
                    `REG_AVG: prdata <= stat_avg;
                    `REG_COUNT: prdata <= stat_count;
                    `REG_QUES_EVENT: prdata <= {16'h0000, ques_event};
                    `REG_QUES_ENABLE: prdata <= {16'h0000, ques_enable};
                    `REG_STATUS: prdata <= {30'h0000_0000, write_reject, offset_held};
                    `REG_RESULT: prdata <= result_data;
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // reading_math_postprocessor

// file: verification/math_postproc_assertions.sv
// Purpose: Port-level checks of the reading math post-processor
// Assumes: Bound to the top module, control word followed from APB writes
// Notes: Bus, reading and output ports only, no internal state is peeked at
`timescale 1ns/1ps
`include "math_postproc_map.vh"
module math_postproc_checker (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    // Readings
    input wire reading_valid,
    input wire [31:0] reading_data,
    input wire func_is_voltage,
    input wire func_is_ratio,
    // Outputs
    input wire result_valid,
    input wire [31:0] result_data,
    input wire srq,
    input wire nv_res_write,
    input wire [4:0] nv_res_data
);
    reg [3:0] ctrl;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    always @(posedge sys_clk or posedge rst) begin
        if (rst) ctrl <= 4'h0;
        else if (psel && penable && pwrite && paddr == `REG_CTRL) ctrl <= pwdata[3:0];
    end
    result_pulse_a: assert property (reading_valid |=> result_valid)
        else $error("result did not follow reading");
    no_spurious_a: assert property (!reading_valid |=> !result_valid)
        else $error("result without reading");
    pass_disabled_a: assert property (reading_valid && !ctrl[3] |=>
        result_data == $past(reading_data)) else $error("disabled reading altered");
    ratio_null_a: assert property (reading_valid && ctrl == 4'hC && func_is_ratio |=>
        result_data == $past(reading_data)) else $error("ratio reading nulled");
    level_volt_a: assert property (reading_valid && (ctrl == 4'h9 || ctrl == 4'hA)
        && !func_is_voltage |=> result_data == $past(reading_data))
        else $error("level math on non-voltage reading");
    srq_cause_a: assert property ($rose(srq) |->
        $past(reading_valid) || $past(psel && pwrite))
        else $error("service request without cause");
    srq_clear_a: assert property ($fell(srq) |-> $past(psel && penable))
        else $error("service request dropped without access");
    nv_write_a: assert property (nv_res_write |-> nv_res_data < 5'h11 &&
        $past(psel && penable && pwrite && paddr == `REG_REF_RES)) else $error("bad store write");
endmodule // math_postproc_checker
bind reading_math_postprocessor math_postproc_checker u_chk (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .reading_valid(reading_valid), .reading_data(reading_data),
    .func_is_voltage(func_is_voltage), .func_is_ratio(func_is_ratio),
    .result_valid(result_valid), .result_data(result_data), .srq(srq),
    .nv_res_write(nv_res_write), .nv_res_data(nv_res_data));

// file: verification/meas_engine_model.sv
// Purpose: Measurement engine model feeding readings and function state
// Assumes: Driven by the bench through its tasks
// Notes: Data bus shows the inverse of the last reading between readings
`timescale 1ns/1ps
module meas_engine_model (
    // Clock
    input wire sys_clk,
    // Readings and function state
    output logic reading_valid = 1'b0,
    output logic [31:0] reading_data = 32'h0,
    output logic [2:0] meas_function = 3'h0,
    output logic func_is_voltage = 1'b1,
    output logic func_is_ratio = 1'b0,
    output logic [31:0] highest_range = 32'h000F_4240,
    // Nonvolatile store
    output logic [4:0] nv_res_index = 5'h03
);
    task automatic send(input logic [31:0] v);
        @(posedge sys_clk);
        reading_valid <= 1'b1;
        reading_data <= v;
        @(posedge sys_clk);
        reading_valid <= 1'b0;
        reading_data <= ~v;
    endtask
    task automatic set_func(input logic [2:0] f, input logic volt, input logic ratio);
        @(posedge sys_clk);
        meas_function <= f;
        func_is_voltage <= volt;
        func_is_ratio <= ratio;
    endtask
endmodule // meas_engine_model

// file: verification/reading_math_postprocessor_tb.sv
// Purpose: Self-checking bench for the reading math post-processor
// Assumes: Zero wait state APB slave, result one cycle after each reading
// Notes: Expected values come from an integer model kept here
`timescale 1ns/1ps
`include "math_postproc_map.vh"
module reading_math_postprocessor_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q;
    wire [31:0] prdata, reading_data, highest_range, result_data;
    wire pready, pslverr, reading_valid, func_is_voltage, func_is_ratio, result_valid, srq;
    wire nv_res_write;
    wire [2:0] meas_function;
    wire [4:0] nv_res_index, nv_res_data;
    int num_errors = 0, check_count = 0, r, lo, hi, sum;
    initial forever #2 sys_clk = ~sys_clk;
    meas_engine_model u_eng (.sys_clk(sys_clk), .reading_valid(reading_valid),
        .reading_data(reading_data), .meas_function(meas_function),
        .func_is_voltage(func_is_voltage), .func_is_ratio(func_is_ratio),
        .highest_range(highest_range), .nv_res_index(nv_res_index));
    reading_math_postprocessor dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reading_valid(reading_valid),
        .reading_data(reading_data), .meas_function(meas_function),
        .func_is_voltage(func_is_voltage), .func_is_ratio(func_is_ratio),
        .highest_range(highest_range), .result_valid(result_valid), .result_data(result_data),
        .srq(srq), .nv_res_index(nv_res_index), .nv_res_write(nv_res_write),
        .nv_res_data(nv_res_data));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic send_chk(input logic [31:0] v, input logic [31:0] exp);
        u_eng.send(v);
        #1;
        chk(result_data, exp);
    endtask
    task automatic summarize;
        if (num_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
    initial begin
        void'($urandom(90558));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(`REG_REF_RES, 32'h3);
        rdchk(`REG_UPPER, 32'h0);
        r = $urandom % 100000;
        send_chk(r, r);
        apb(1'b1, `REG_CTRL, 32'hC);
        send_chk(r, 32'h0);
        lo = $urandom % 100000;
        send_chk(lo, lo - r);
        u_eng.set_func(3'h1, 1'b1, 1'b0);
        apb(1'b1, `REG_CTRL, 32'h4);
        apb(1'b1, `REG_OFFSET, 32'h5);
        rdchk(`REG_STATUS, 32'h2);
        apb(1'b1, `REG_CTRL, 32'hC);
        apb(1'b1, `REG_OFFSET, 32'd77);
        send_chk(r, r - 77);
        u_eng.set_func(3'h2, 1'b0, 1'b1);
        for (int op = 0; op < 3; op++) begin
            apb(1'b1, `REG_CTRL, 32'h8 | (op == 0 ? 4 : op));
            r = $urandom % 100000;
            send_chk(r, r);
        end
        apb(1'b1, `REG_REF_RES, 32'd16);
        apb(1'b1, `REG_REF_RES, 32'd17);
        rdchk(`REG_REF_RES, 32'd16);
        apb(1'b1, `REG_CTRL, 32'h0);
        apb(1'b1, `REG_CTRL, 32'h8);
        lo = 32'h7FFF_FFFF;
        hi = 0;
        sum = 0;
        repeat (5) begin
            r = $urandom % 100000;
            u_eng.send(r);
            lo = r < lo ? r : lo;
            hi = r > hi ? r : hi;
            sum += r;
        end
        repeat (60) @(posedge sys_clk);
        rdchk(`REG_MIN, lo);
        rdchk(`REG_MAX, hi);
        rdchk(`REG_COUNT, 32'd5);
        rdchk(`REG_AVG, sum / 5);
        apb(1'b1, `REG_CTRL, 32'h0);
        apb(1'b1, `REG_CTRL, 32'h8);
        rdchk(`REG_COUNT, 32'h0);
        apb(1'b1, `REG_CTRL, 32'hB);
        apb(1'b1, `REG_UPPER, 32'd1000);
        apb(1'b1, `REG_LOWER, -32'sd1000);
        apb(1'b1, `REG_QUES_ENABLE, 32'h1800);
        u_eng.send(32'd2000);
        rdchk(`REG_QUES_EVENT, 32'h800);
        rdchk(`REG_QUES_EVENT, 32'h0);
        u_eng.send(-32'sd2000);
        #1;
        chk({31'h0, srq}, 32'h1);
        apb(1'b1, `REG_STATUS, 32'h1);
        rdchk(`REG_QUES_EVENT, 32'h0);
        u_eng.set_func(3'h3, 1'b1, 1'b0);
        rdchk(`REG_UPPER, 32'h0);
        apb(1'b1, `REG_CTRL, 32'hA);
        apb(1'b1, `REG_LEVEL_REF, -32'sd500);
        apb(1'b1, `REG_LEVEL_REF, 32'd20001);
        rdchk(`REG_LEVEL_REF, -32'sd500);
        // 2^20 uV into 8000 ohms, accepted within 0.6 dB of the exact level
        hi = $rtoi(1000.0 * $log10(1.048576 * 1.048576 / 8.0));
        u_eng.send(32'h0010_0000);
        #1;
        r = $signed(result_data) - hi;
        chk(r * r < 3600, 32'h1);
        apb(1'b1, `REG_CTRL, 32'h9);
        u_eng.send(32'h0010_0000);
        #1;
        r = $signed(result_data) - hi - 500;
        chk(r * r < 3600, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, pslverr}, 32'h1);
        summarize();
    end
endmodule // reading_math_postprocessor_tb
